// *** hw/pfc_flash_ctrl.v ***
// program flash command, mode and event status registers
// assumes an AXI4-Lite master on sys_clk and a flash array port
`timescale 1ns/1ps
`include "pfc_consts.vh"
// Summary of operation
// - start bit and command field clear themselves when an operation ends
// - start write while busy is ignored; valid command raises overlap error
// - start with prohibited code 111 raises undefined-command error
// - command field bits 6:4 select none, program, erases, option ops
// - option erase wipes protection and configuration option words together
// - control writes ignored while any raw error flag is set
// - control writes ignored while busy or with a bad unlock key
// - mode bit 0 lets entire erase include the boot area
// - mode bits 5:4 choose one to four read wait cycles
// - mode bit 8 enables prefetch; wait field unused when it is zero
// - mask register enables done at bit 0, errors at bits 10:8
// - raw status shows done at bit 0 and errors at bits 10:8
// - writing one to clear register bits clears matching flags
// - state register bit 0 reads one while programming or erasing
// - data register holds the word a program command writes
// - start accepted only with key 5a5a5a5a; key clears after operation
// - operation on a protected area raises third error, flash untouched
// - page erase targets the 1 Kbyte page holding the address
// - sector erase targets the 32 Kbyte sector holding the address
module pfc_flash_ctrl #(
    parameter PROG_CYCLES = 16,
    parameter ERASE_CYCLES = 64
) (
    // clock and reset
    input wire sys_clk,
    input wire rstn,
    // axi4-lite write address
    input wire [5:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    // axi4-lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    // axi4-lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // axi4-lite read address
    input wire [5:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    // axi4-lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // protection input from the array, asynchronous pin
    input wire areaProtected,
    // flash array operation port
    output reg flashOpValid,
    output reg [2:0] flashOpCmd,
    output reg [31:0] flashOpAddr,
    output reg [31:0] program_word,
    output reg flashBootErase,
    output reg optionWordWipe,
    // read timing to the fetch path
    output reg prefetch_enable,
    output reg [2:0] readWaitCycles,
    // interrupt
    output reg flashIrq
);
    wire rstnSync;
    reg protMeta;
    reg protSync;
    reg [31:0] flash_mode;
    reg [31:0] irq_mask_set_clear;
    reg [31:0] target_address;
    reg [31:0] write_data_word;
    reg [31:0] unlock_key;
    reg [2:0] cmdField;
    reg startBit;
    reg done;
    reg [2:0] error_flags;
    reg busy;
    reg [2:0] runCmd;
    reg opStart;
    reg [5:0] wAddr;
    reg haveAw;
    reg haveW;
    reg [31:0] wData;
    reg [3:0] wStrb;
    wire timerRun;
    wire timerFinish;
    wire doWrite = haveAw && haveW && !s_axi_bvalid;
    wire [2:0] wCmd = wData[`PFC_CMD_HI:`PFC_CMD_LO];
    wire wStart = wData[`PFC_START_BIT] && wStrb[0];
    wire ctrlWr = doWrite && (wAddr == `PFC_OFF_CTRL);
    wire clrWr = doWrite && (wAddr == `PFC_OFF_CLR);
    wire keyOk = (unlock_key == `PFC_KEY_OK);
    wire anyErr = |error_flags;
    wire ctrlTake = ctrlWr && !busy && !anyErr && keyOk;
    wire goodCmd = (wCmd != `PFC_CMD_NONE) && (wCmd != `PFC_CMD_BAD);
    wire eraseCls = (runCmd != `PFC_CMD_WORD) && (runCmd != `PFC_CMD_OPTP);
    // a protected target never starts the timer, so busy lasts one cycle
    wire timerGo = opStart && !protSync;
    // array strobes share one qualifier so they rise and fall together
    wire opLive = busy && timerRun && !protSync;
    wire [2:0] rawErr = {1'b0, 1'b0, 1'b0};
    wire [10:0] rawEv = {error_flags, 7'h00, done};
    wire [10:0] mskEv = rawEv & irq_mask_set_clear[`PFC_ERR_HI:0];
    reg [2:0] setErr;
    reg mapped;
    reg [31:0] rdVal;

    pfc_reset_sync u_rst (
        .sysClk(sys_clk),
        .rstnIn(rstn),
        .rstnOut(rstnSync)
    );

    pfc_op_timer #(
        .PROG_CYCLES(PROG_CYCLES),
        .ERASE_CYCLES(ERASE_CYCLES)
    ) u_timer (
        .sysClk(sys_clk),
        .rstn(rstnSync),
        .start(timerGo),
        .isErase(eraseCls),
        .running(timerRun),
        .finish(timerFinish)
    );

    // protection pin passes two flops before use
    always @(posedge sys_clk or negedge rstnSync) begin
        if (!rstnSync) begin
            protMeta <= 1'b0;
            protSync <= 1'b0;
        end else begin
            protMeta <= areaProtected;
            protSync <= protMeta;
        end
    end

    // error events raised this cycle
    always @* begin
        setErr = rawErr;
        if (ctrlWr && wStart && busy && goodCmd)
            setErr[0] = 1'b1;
        if (ctrlWr && wStart && !busy && !anyErr && wCmd == `PFC_CMD_BAD)
            setErr[1] = 1'b1;
        if (opStart && protSync && runCmd != `PFC_CMD_NONE)
            setErr[2] = 1'b1;
    end

    // write channel capture, address and data in either order
    always @(posedge sys_clk or negedge rstnSync) begin
        if (!rstnSync) begin
            haveAw <= 1'b0;
            haveW <= 1'b0;
            wAddr <= 6'h00;
            wData <= `PFC_ZERO32;
            wStrb <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `PFC_RESP_OK;
        end else begin
            // ready idles high every other cycle so a held valid is taken once
            s_axi_awready <= !haveAw && !s_axi_awready && !s_axi_bvalid;
            s_axi_wready <= !haveW && !s_axi_wready && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                haveAw <= 1'b1;
                wAddr <= {s_axi_awaddr[5:2], 2'b00};
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                haveW <= 1'b1;
                wData <= s_axi_wdata;
                wStrb <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (doWrite) begin
                haveAw <= 1'b0;
                haveW <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wAddr >= `PFC_OFF_CTRL &&
                    wAddr <= `PFC_OFF_KEY) ? `PFC_RESP_OK : `PFC_RESP_ERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // register file and command sequencing
    always @(posedge sys_clk or negedge rstnSync) begin
        if (!rstnSync) begin
            flash_mode <= `PFC_ZERO32;
            irq_mask_set_clear <= `PFC_ZERO32;
            target_address <= `PFC_ZERO32;
            write_data_word <= `PFC_ZERO32;
            unlock_key <= `PFC_ZERO32;
            cmdField <= `PFC_CMD_NONE;
            startBit <= 1'b0;
            done <= 1'b0;
            error_flags <= 3'h0;
            busy <= 1'b0;
            runCmd <= `PFC_CMD_NONE;
            opStart <= 1'b0;
        end else begin
            opStart <= 1'b0;
            // setup writes during a run are dropped so the array sees one job
            if (doWrite && !busy) begin
                case (wAddr)
                    `PFC_OFF_MODE: flash_mode <= wData;
                    `PFC_OFF_MASK: irq_mask_set_clear <= wData;
                    `PFC_OFF_ADDR: target_address <= wData;
                    `PFC_OFF_DATA: write_data_word <= wData;
                    `PFC_OFF_KEY: unlock_key <= wData;
                    default: ;
                endcase
            end
            if (ctrlTake) begin
                cmdField <= wCmd;
                if (wStart && goodCmd) begin
                    startBit <= 1'b1;
                    runCmd <= wCmd;
                    opStart <= 1'b1;
                    busy <= 1'b1;
                end
            end
            // a protected start ends at once and drops the key like a finish
            if (opStart && protSync) begin
                busy <= 1'b0;
                startBit <= 1'b0;
                cmdField <= `PFC_CMD_NONE;
                unlock_key <= `PFC_ZERO32;
            end
            if (timerFinish && busy) begin
                busy <= 1'b0;
                startBit <= 1'b0;
                cmdField <= `PFC_CMD_NONE;
                target_address <= `PFC_ZERO32;
                write_data_word <= `PFC_ZERO32;
                unlock_key <= `PFC_ZERO32;
            end
            // set wins over a clear in the same cycle
            if (clrWr && wData[`PFC_DONE_BIT] && wStrb[0])
                done <= 1'b0;
            if (timerFinish && busy)
                done <= 1'b1;
            // hardware set beats a software clear in the same cycle
            error_flags <= (error_flags &
                ~(wData[`PFC_ERR_HI:`PFC_ERR_LO] & {3{clrWr && wStrb[1]}}))
                | setErr;
        end
    end

    // flash array drive and read timing outputs
    always @(posedge sys_clk or negedge rstnSync) begin
        if (!rstnSync) begin
            flashOpValid <= 1'b0;
            flashOpCmd <= `PFC_CMD_NONE;
            flashOpAddr <= `PFC_ZERO32;
            program_word <= `PFC_ZERO32;
            flashBootErase <= 1'b0;
            optionWordWipe <= 1'b0;
            prefetch_enable <= 1'b0;
            readWaitCycles <= 3'h1;
            flashIrq <= 1'b0;
        end else begin
            // the array is never driven for a protected target
            flashOpValid <= opLive;
            flashOpCmd <= runCmd;
            program_word <= write_data_word;
            case (runCmd)
                `PFC_CMD_PAGE:
                    flashOpAddr <= target_address & `PFC_PAGE_MASK;
                `PFC_CMD_SECT:
                    flashOpAddr <= target_address & `PFC_SECT_MASK;
                `PFC_CMD_ALL: flashOpAddr <= `PFC_ZERO32;
                default: flashOpAddr <= target_address;
            endcase
            flashBootErase <= opLive && runCmd == `PFC_CMD_ALL &&
                flash_mode[`PFC_BOOT_BIT];
            optionWordWipe <= opLive && runCmd == `PFC_CMD_OPTE;
            prefetch_enable <= flash_mode[`PFC_PREF_BIT];
            // wait field only counts with prefetch on
            readWaitCycles <= flash_mode[`PFC_PREF_BIT] ?
                ({1'b0, flash_mode[`PFC_WAIT_HI:`PFC_WAIT_LO]} + 3'h1)
                : 3'h1;
            flashIrq <= |mskEv;
        end
    end

    // read decode
    always @* begin
        rdVal = `PFC_ZERO32;
        mapped = 1'b1;
        case ({s_axi_araddr[5:2], 2'b00})
            `PFC_OFF_CTRL: rdVal = {25'h0, cmdField, 3'h0,
                startBit};
            `PFC_OFF_MODE: rdVal = {23'h0, flash_mode[`PFC_PREF_BIT],
                2'h0, flash_mode[`PFC_WAIT_HI:`PFC_WAIT_LO], 3'h0,
                flash_mode[`PFC_BOOT_BIT]};
            `PFC_OFF_MASK: rdVal = {21'h0,
                irq_mask_set_clear[`PFC_ERR_HI:`PFC_ERR_LO], 7'h0,
                irq_mask_set_clear[`PFC_DONE_BIT]};
            `PFC_OFF_RAW: rdVal = {21'h0, rawEv};
            `PFC_OFF_MSK: rdVal = {21'h0, mskEv};
            `PFC_OFF_CLR: rdVal = `PFC_ZERO32;
            `PFC_OFF_STATE: rdVal = {31'h0, busy};
            `PFC_OFF_ADDR: rdVal = target_address;
            `PFC_OFF_DATA: rdVal = write_data_word;
            `PFC_OFF_KEY: rdVal = unlock_key;
            default: mapped = 1'b0;
        endcase
    end

    // read channel
    always @(posedge sys_clk or negedge rstnSync) begin
        if (!rstnSync) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= `PFC_ZERO32;
            s_axi_rresp <= `PFC_RESP_OK;
        end else begin
            // data is taken at the address handshake and held until rready
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rdVal;
                s_axi_rresp <= mapped ? `PFC_RESP_OK : `PFC_RESP_ERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule

// *** hw/pfc_consts.vh ***
// constants for the program flash command controller
// assumes inclusion by the two design files that use it and the two bench files
`ifndef PFC_CONSTS_VH
`define PFC_CONSTS_VH
`define PFC_OFF_CTRL 6'h0c
`define PFC_OFF_MODE 6'h10
`define PFC_OFF_MASK 6'h14
`define PFC_OFF_RAW 6'h18
`define PFC_OFF_MSK 6'h1c
`define PFC_OFF_CLR 6'h20
`define PFC_OFF_STATE 6'h24
`define PFC_OFF_ADDR 6'h28
`define PFC_OFF_DATA 6'h2c
`define PFC_OFF_KEY 6'h30
`define PFC_START_BIT 0
`define PFC_CMD_HI 6
`define PFC_CMD_LO 4
`define PFC_DONE_BIT 0
`define PFC_ERR_HI 10
`define PFC_ERR_LO 8
`define PFC_ERR_OVL 8
`define PFC_ERR_UND 9
`define PFC_ERR_PROT 10
`define PFC_BOOT_BIT 0
`define PFC_WAIT_HI 5
`define PFC_WAIT_LO 4
`define PFC_PREF_BIT 8
`define PFC_BUSY_BIT 0
`define PFC_CMD_NONE 3'h0
`define PFC_CMD_WORD 3'h1
`define PFC_CMD_PAGE 3'h2
`define PFC_CMD_SECT 3'h3
`define PFC_CMD_ALL 3'h4
`define PFC_CMD_OPTP 3'h5
`define PFC_CMD_OPTE 3'h6
`define PFC_CMD_BAD 3'h7
`define PFC_KEY_OK 32'h5a5a5a5a
`define PFC_PAGE_MASK 32'hfffffc00
`define PFC_SECT_MASK 32'hffff8000
`define PFC_ZERO32 32'h00000000
`define PFC_RESP_OK 2'h0
`define PFC_RESP_ERR 2'h2
`endif

// *** hw/pfc_reset_sync.v ***
// reset synchroniser: async assert, two-flop release
// assumes rstn is asynchronous to sys_clk
`timescale 1ns/1ps
module pfc_reset_sync (
    // clock and raw reset
    input wire sysClk,
    input wire rstnIn,
    // synchronised reset
    output reg rstnOut
);
    reg stage1;
    always @(posedge sysClk or negedge rstnIn) begin
        if (!rstnIn) begin
            stage1 <= 1'b0;
            rstnOut <= 1'b0;
        end else begin
            stage1 <= 1'b1;
            rstnOut <= stage1;
        end
    end
endmodule

// *** hw/pfc_op_timer.v ***
// operation timer: runs for a fixed count per command class
// assumes start is a single-cycle pulse from the controller
`timescale 1ns/1ps
`include "pfc_consts.vh"
module pfc_op_timer #(
    parameter PROG_CYCLES = 16,
    parameter ERASE_CYCLES = 64
) (
    // clock and reset
    input wire sysClk,
    input wire rstn,
    // control
    input wire start,
    input wire isErase,
    // status
    output reg running,
    output reg finish
);
    reg [15:0] count;
    always @(posedge sysClk or negedge rstn) begin
        if (!rstn) begin
            count <= 16'h0000;
            running <= 1'b0;
            finish <= 1'b0;
        end else begin
            finish <= 1'b0;
            if (start && !running) begin
                running <= 1'b1;
                count <= isErase ? ERASE_CYCLES[15:0] : PROG_CYCLES[15:0];
            end else if (running) begin
                if (count <= 16'h0001) begin
                    running <= 1'b0;
                    finish <= 1'b1;
                end else begin
                    count <= count - 16'h0001;
                end
            end
        end
    end
endmodule

// *** testbench/pfc_flash_ctrl_sva.sv ***
// port assertions for the flash command controller
// assumes binding onto pfc_flash_ctrl, one clock domain
`timescale 1ns/1ps
`include "pfc_consts.vh"
module pfc_flash_ctrl_sva #(
    parameter PROG_CYCLES = 16,
    parameter ERASE_CYCLES = 64
) (
    // clock and reset
    input wire sys_clk,
    input wire rstn,
    // write response
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [1:0] s_axi_bresp,
    // array port
    input wire flashOpValid,
    input wire [2:0] flashOpCmd,
    input wire [31:0] flashOpAddr,
    input wire flashBootErase,
    input wire optionWordWipe,
    // read timing
    input wire prefetch_enable,
    input wire [2:0] readWaitCycles
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    property p_wait_off;
        !prefetch_enable |-> readWaitCycles == 3'h1;
    endproperty
    a_wait_off: assert property (p_wait_off) else $error("wait not 1");
    property p_wait_rng;
        readWaitCycles inside {[3'h1:3'h4]};
    endproperty
    a_wait_rng: assert property (p_wait_rng) else $error("wait range");
    property p_boot;
        flashBootErase |-> flashOpValid && flashOpCmd == `PFC_CMD_ALL;
    endproperty
    a_boot: assert property (p_boot) else $error("boot erase");
    property p_optw;
        optionWordWipe |-> flashOpValid && flashOpCmd == `PFC_CMD_OPTE;
    endproperty
    a_optw: assert property (p_optw) else $error("option wipe");
    property p_page;
        flashOpValid && flashOpCmd == `PFC_CMD_PAGE |->
            flashOpAddr[9:0] == 10'h000;
    endproperty
    a_page: assert property (p_page) else $error("page align");
    property p_sect;
        flashOpValid && flashOpCmd == `PFC_CMD_SECT |->
            flashOpAddr[14:0] == 15'h0000;
    endproperty
    a_sect: assert property (p_sect) else $error("sector align");
    property p_cmd_ok;
        flashOpValid |-> flashOpCmd inside {[3'h1:3'h6]};
    endproperty
    a_cmd_ok: assert property (p_cmd_ok) else $error("bad op code");
    property p_hold;
        flashOpValid && $past(flashOpValid) |->
            $stable(flashOpCmd) && $stable(flashOpAddr);
    endproperty
    a_hold: assert property (p_hold) else $error("op changed");
    property p_bound;
        $rose(flashOpValid) |-> ##[1:200] !flashOpValid;
    endproperty
    a_bound: assert property (p_bound) else $error("op never ends");
    property p_bhold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_bhold: assert property (p_bhold) else $error("bresp dropped");
    c_word: cover property ($rose(flashOpValid) && flashOpCmd == 3'h1);
    c_boot: cover property (flashBootErase);
    c_wipe: cover property (optionWordWipe);
endmodule

bind pfc_flash_ctrl pfc_flash_ctrl_sva #(
    .PROG_CYCLES(PROG_CYCLES),
    .ERASE_CYCLES(ERASE_CYCLES)
) i_sva (
    .sys_clk, .rstn, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .flashOpValid, .flashOpCmd, .flashOpAddr, .flashBootErase,
    .optionWordWipe, .prefetch_enable, .readWaitCycles
);

// *** testbench/pfc_flash_array_model.sv ***
// behavioural flash array on the controller's operation port
// assumes the bench sets protMode to mark every target protected
`timescale 1ns/1ps
module pfc_flash_array_model (
    // clock
    input wire sys_clk,
    // operation port
    input wire flashOpValid,
    input wire [31:0] program_word,
    // protection
    input wire protMode,
    output reg areaProtected,
    // bench view
    output int opCnt,
    output reg [31:0] lastWord
);
    reg opPrev = 1'b0;
    initial begin
        areaProtected = 1'b0;
        opCnt = 0;
        lastWord = 32'h00000000;
    end
    // the pin is registered, so it reaches the controller a cycle late
    always @(posedge sys_clk) begin
        areaProtected <= protMode;
        opPrev <= flashOpValid;
        if (flashOpValid && !opPrev) begin
            opCnt <= opCnt + 1;
            lastWord <= program_word;
        end
    end
endmodule

// *** testbench/pfc_flash_ctrl_tb.sv ***
// self-checking bench for the flash command controller
// assumes the design under hw and the array model beside this file
`timescale 1ns/1ps
`include "pfc_consts.vh"
module pfc_flash_ctrl_tb;
    localparam [1:0] OK = `PFC_RESP_OK;
    reg sysClk = 1'b0, rstn = 1'b0, protMode = 1'b0;
    reg [5:0] awAddr = 6'h00, arAddr = 6'h00;
    reg [31:0] wData = 32'h0;
    reg awValid = 1'b0, wValid = 1'b0, bReady = 1'b0;
    reg arValid = 1'b0, rReady = 1'b0;
    wire awReady, wReady, bValid, arReady, rValid, areaProt;
    wire opValid, pref, boot, optWipe, irq;
    wire [1:0] bResp, rResp;
    wire [2:0] opCmd, waitCyc;
    wire [31:0] rData, opAddr, pWord, lastWord;
    int opCnt, errorCnt = 0, testsRun = 0, cyc = 0, i, j;
    reg [31:0] r, a, d, e;
    reg [31:0] expQ[$];
    reg [1:0] respQ[$];
    reg [1:0] rrespQ[$];
    reg [5:0] offs[8] = '{`PFC_OFF_MODE, `PFC_OFF_MASK, `PFC_OFF_RAW,
        `PFC_OFF_MSK, `PFC_OFF_STATE, `PFC_OFF_ADDR, `PFC_OFF_DATA,
        `PFC_OFF_KEY};

    // short counts keep the run brief; checks wait on opValid instead of using these counts
    pfc_flash_ctrl #(.PROG_CYCLES(12), .ERASE_CYCLES(24)) i_dut (
        .sys_clk(sysClk), .rstn(rstn),
        .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
        .s_axi_awready(awReady), .s_axi_wdata(wData),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
        .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
        .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
        .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
        .s_axi_rvalid(rValid), .s_axi_rready(rReady),
        .areaProtected(areaProt), .flashOpValid(opValid),
        .flashOpCmd(opCmd), .flashOpAddr(opAddr), .program_word(pWord),
        .flashBootErase(boot), .optionWordWipe(optWipe),
        .prefetch_enable(pref), .readWaitCycles(waitCyc), .flashIrq(irq)
    );
    pfc_flash_array_model i_array (
        .sys_clk(sysClk), .flashOpValid(opValid), .program_word(pWord),
        .protMode(protMode), .areaProtected(areaProt), .opCnt(opCnt),
        .lastWord(lastWord)
    );

    task chk(input string nm, input [31:0] seen, input [31:0] exp);
        testsRun++;
        if (seen !== exp) begin
            errorCnt++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task end_sim;
        if (errorCnt == 0 && testsRun > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task wr(input [5:0] ad, input [31:0] dt, input [1:0] rs);
        respQ.push_back(rs);
        awAddr <= ad;
        wData <= dt;
        awValid <= 1'b1;
        wValid <= 1'b1;
        bReady <= 1'b1;
        do begin
            @(posedge sysClk);
            if (awReady) awValid <= 1'b0;
            if (wReady) wValid <= 1'b0;
        end while (!bValid);
        bReady <= 1'b0;
        @(posedge sysClk);
    endtask
    task rd(input [5:0] ad, input [31:0] ex, input [1:0] rs = 2'h0);
        expQ.push_back(ex);
        rrespQ.push_back(rs);
        arAddr <= ad;
        arValid <= 1'b1;
        rReady <= 1'b1;
        do begin
            @(posedge sysClk);
            if (arReady) arValid <= 1'b0;
        end while (!rValid);
        rReady <= 1'b0;
        @(posedge sysClk);
    endtask
    task go(input [2:0] c);
        wr(`PFC_OFF_KEY, `PFC_KEY_OK, OK);
        wr(`PFC_OFF_CTRL, {25'h0, c, 4'h1}, OK);
    endtask

    initial begin
        forever #5 sysClk = ~sysClk;
    end
    // result watcher: answers are matched against notes in issue order
    always @(posedge sysClk) begin
        cyc <= cyc + 1;
        if (bValid && bReady) chk("bresp", bResp, respQ.pop_front());
        if (rValid && rReady) chk("rdata", rData, expQ.pop_front());
        if (rValid && rReady) chk("rresp", rResp, rrespQ.pop_front());
        if (cyc == 6000) begin
            errorCnt++;
            end_sim();
        end
    end

    initial begin
        void'($urandom(90839));
        repeat (4) @(posedge sysClk);
        rstn <= 1'b1;
        repeat (3) @(posedge sysClk);
        foreach (offs[k]) rd(offs[k], 32'h0);
        chk("waitcyc", waitCyc, 1);
        r = $urandom;
        wr(`PFC_OFF_MODE, r, OK);
        rd(`PFC_OFF_MODE, r & 32'h131);
        repeat (2) @(posedge sysClk);
        chk("waitcyc", waitCyc, r[8] ? r[5:4] + 1 : 1);
        for (i = 0; i < 4; i++) begin
            wr(`PFC_OFF_MODE, 32'h101 | (i << 4), OK);
            repeat (2) @(posedge sysClk);
            chk("waitcyc", waitCyc, i + 1);
            chk("prefetch", pref, 1);
        end
        r = $urandom;
        wr(`PFC_OFF_MASK, r, OK);
        rd(`PFC_OFF_MASK, r & 32'h701);
        wr(`PFC_OFF_MASK, 32'h701, OK);
        wr(6'h3c, r, `PFC_RESP_ERR);
        rd(6'h04, 32'h0, `PFC_RESP_ERR);
        wr(`PFC_OFF_CTRL, 32'h71, OK);
        rd(`PFC_OFF_RAW, 32'h200);
        rd(`PFC_OFF_MSK, 32'h200);
        chk("irq", irq, 1);
        go(`PFC_CMD_WORD);
        rd(`PFC_OFF_STATE, 32'h0);
        wr(`PFC_OFF_CLR, 32'h0, OK);
        rd(`PFC_OFF_RAW, 32'h200);
        wr(`PFC_OFF_CLR, 32'h200, OK);
        rd(`PFC_OFF_RAW, 32'h0);
        chk("irq", irq, 0);
        wr(`PFC_OFF_KEY, 32'h5a5a5a5b, OK);
        wr(`PFC_OFF_CTRL, 32'h11, OK);
        rd(`PFC_OFF_STATE, 32'h0);
        chk("ops", opCnt, 0);
        for (i = 1; i < 7; i++) begin
            a = (i == 5) ? 32'h400 : $urandom & 32'h3fffc;
            d = $urandom;
            wr(`PFC_OFF_ADDR, a, OK);
            wr(`PFC_OFF_DATA, d, OK);
            rd(`PFC_OFF_DATA, d);
            go(i[2:0]);
            @(posedge sysClk);
            e = (i == 2) ? a & `PFC_PAGE_MASK : a;
            e = (i == 3) ? a & `PFC_SECT_MASK : e;
            chk("cmd", opCmd, i);
            if (i != 4 && i != 6) chk("addr", opAddr, e);
            if (i == 1 || i == 5) chk("word", pWord, d);
            chk("boot", boot, i == 4);
            chk("optwipe", optWipe, i == 6);
            rd(`PFC_OFF_STATE, 32'h1);
            if (i == 2) wr(`PFC_OFF_CTRL, 32'h31, OK);
            for (j = 0; j < 300 && opValid; j++) @(posedge sysClk);
            repeat (3) @(posedge sysClk);
            rd(`PFC_OFF_RAW, (i == 2) ? 32'h101 : 32'h1);
            rd(`PFC_OFF_CTRL, 32'h0);
            rd(`PFC_OFF_KEY, 32'h0);
            wr(`PFC_OFF_CLR, 32'h701, OK);
        end
        chk("ops", opCnt, 6);
        wr(`PFC_OFF_MASK, 32'h700, OK);
        protMode <= 1'b1;
        repeat (4) @(posedge sysClk);
        go(`PFC_CMD_WORD);
        repeat (6) @(posedge sysClk);
        rd(`PFC_OFF_MSK, 32'h400);
        rd(`PFC_OFF_STATE, 32'h0);
        chk("ops", opCnt, 6);
        repeat (3) @(posedge sysClk);
        end_sim();
    end
endmodule
